// file: hw/usbc_ctrl.sv
// USB endpoint control logic with its receive FIFO
`timescale 1ns/1ps

//----------------------------------------------------------------------
// Receive FIFO
//----------------------------------------------------------------------
module usbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words
	logic [AW-1:0] wr_q; // Write pointer
	logic [AW-1:0] rd_q; // Read pointer
	logic [AW:0] cnt_q; // Fill level
	logic push;
	logic pop;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;
	// Storage has no reset: only written words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	// Pointers and level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//----------------------------------------------------------------------
// Endpoint control top
//----------------------------------------------------------------------
module usbc_ctrl
	import usbc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic dp_i,
	output logic dp_o,
	output logic dp_oe,
	input wire logic dm_i,
	output logic dm_o,
	output logic dm_oe,
	output logic pullup_on,
	input wire logic sie_oe,
	input wire logic sie_dp,
	input wire logic sie_dm,
	input wire usbc_tok_t tok,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	output logic rx_ready,
	input wire logic host_ack,
	input wire logic host_timeout,
	output usbc_resp_t resp,
	output logic rxf_valid,
	input wire logic rxf_ready,
	output logic [7:0] rxf_data,
	output logic wake,
	output logic irq
);
	//------------------------------------------------------------------
	// Register file
	//------------------------------------------------------------------
	logic [7:0] ctl_q [NUM_CTL]; // Control registers E4..E9
	logic [7:0] flag_q; // Sticky status flags
	logic [7:0] rdata_q; // Read data holding
	logic [7:0] flag_set; // Hardware set pulses
	logic setup_hit; // SETUP token accepted
	logic usb_on;
	assign usb_on = ctl_q[0][B_USB_ON];

	// Control writes; SETUP clears both control halts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CTL; i++) ctl_q[i] <= RST_VAL;
		end else if (ce) begin
			for (int i = 0; i < NUM_CTL; i++) begin
				if (sfr_wr && sfr_addr == OFS_GLOBAL + 8'(i)) begin
					ctl_q[i] <= sfr_wdata;
				end
			end
			if (setup_hit) begin
				ctl_q[1][B_HALT] <= 1'b0;
				ctl_q[2][B_RX_RDY] <= 1'b0;
			end
		end
	end

	// Write-one clears, but a same-cycle set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= RST_VAL;
		end else if (ce) begin
			flag_q <= (flag_q & ~((sfr_wr && sfr_addr == OFS_STATUS)
				? sfr_wdata : 8'h00)) | flag_set;
		end
	end

	// Read port; unmapped offsets return zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RST_VAL;
		end else if (ce && sfr_rd) begin
			rdata_q <= 8'h00;
			for (int i = 0; i < NUM_CTL; i++) begin
				if (sfr_addr == OFS_GLOBAL + 8'(i)) rdata_q <= ctl_q[i];
			end
			if (sfr_addr == OFS_STATUS) rdata_q <= flag_q;
		end
	end
	assign sfr_rdata = rdata_q;

	// One request line, resume always enabled
	assign irq = |(flag_q[6:0] & ctl_q[4][6:0])
		| flag_q[F_RESUME];
	assign wake = flag_q[F_RESUME];

	//------------------------------------------------------------------
	// Line sampling and pin drive
	//------------------------------------------------------------------
	logic [1:0] sy1_q, sy2_q, sy3_q; // Three-stage samplers {dp,dm}
	logic [1:0] line_q; // Filtered line state
	logic [7:0] se0_cnt_q; // SE0 length counter
	logic se0_seen_q; // SE0 before J, for EOP
	logic se0;
	logic jst;

	// Sampler chain; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q <= 2'h2;
			sy2_q <= 2'h2;
			sy3_q <= 2'h2;
		end else if (ce) begin
			sy1_q <= {dp_i, dm_i};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// Per-bit filter: change taken once stages two and three agree
	for (genvar b = 0; b < 2; b++) begin : g_line
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				line_q[b] <= (b == 1);
			end else if (ce && sy2_q[b] == sy3_q[b]) begin
				line_q[b] <= sy2_q[b];
			end
		end
	end
	assign se0 = (line_q == 2'h0);
	assign jst = (line_q == 2'h2);

	// Bus reset and EOP detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			se0_cnt_q <= 8'h00;
			se0_seen_q <= 1'b0;
		end else if (ce) begin
			if (!usb_on || !se0) se0_cnt_q <= 8'h00;
			else if (se0_cnt_q != 8'(BUSRST_CYC)) se0_cnt_q <= se0_cnt_q + 8'h01;
			if (se0) se0_seen_q <= usb_on;
			else if (jst) se0_seen_q <= 1'b0;
		end
	end

	// Pin drive: forced output first, then resume K, then engine
	always_comb begin
		dp_oe = 1'b0;
		dm_oe = 1'b0;
		dp_o = 1'b0;
		dm_o = 1'b0;
		if (ctl_q[0][B_FORCE]) begin
			dp_oe = 1'b1;
			dm_oe = 1'b1;
			dp_o = ctl_q[0][B_FDP];
			dm_o = ctl_q[0][B_FDM];
		end else if (usb_on && ctl_q[0][B_FRES]) begin
			dp_oe = 1'b1;
			dm_oe = 1'b1;
			dm_o = 1'b1;
		end else if (usb_on && sie_oe) begin
			dp_oe = 1'b1;
			dm_oe = 1'b1;
			dp_o = sie_dp;
			dm_o = sie_dm;
		end
	end
	assign pullup_on = ctl_q[0][B_PULL] && usb_on;

	//------------------------------------------------------------------
	// Transaction sequencer
	//------------------------------------------------------------------
	typedef enum logic [2:0] {
		USBC_ST_IDLE = 3'b001,
		USBC_ST_RX = 3'b010,
		USBC_ST_ACK = 3'b100
	} usbc_state_t;
	usbc_state_t st_q; // Current state
	usbc_resp_t resp_q; // Registered answer
	logic [1:0] ep_q; // Endpoint of transaction
	logic setup_q; // Transaction is SETUP
	logic take_q; // Data is being stored
	logic halt_q; // Answer STALL at end
	logic hit; // Token addressed and enabled
	logic [7:0] epc; // Selected endpoint control
	logic ep_halt; // Selected halt bit
	logic tx_done; // Selected transmit done flag
	logic rx_done; // Selected receive done flag
	logic rx_ok; // OUT may be stored
	logic fifo_ready;

	// Endpoint selection and enables
	always_comb begin
		epc = ctl_q[1];
		ep_halt = ctl_q[2][B_RX_RDY];
		tx_done = flag_q[F_TX0];
		rx_done = flag_q[F_RX0];
		hit = 1'b0;
		case (tok.ep)
			2'h0: hit = 1'b1;
			2'h1: begin
				epc = ctl_q[2];
				ep_halt = ctl_q[2][B_HALT];
				tx_done = flag_q[F_TX1];
				rx_done = 1'b1;
				hit = ctl_q[0][B_EP1_ON]
					&& (tok.kind == USBC_TK_IN || ep_halt);
			end
			2'h2: begin
				epc = ctl_q[3];
				ep_halt = ctl_q[3][B_HALT];
				tx_done = flag_q[F_TX2];
				rx_done = flag_q[F_RX2];
				hit = ctl_q[0][B_EP2_ON];
			end
			default: hit = 1'b0;
		endcase
		if (tok.ep == 2'h0 && tok.kind != USBC_TK_IN) begin
			ep_halt = ctl_q[1][B_HALT];
		end
		hit = hit && tok.valid && usb_on
			&& tok.addr == ctl_q[5][6:0];
	end
	assign rx_ok = epc[B_RX_RDY] && !rx_done;
	assign setup_hit = ce && hit && st_q == USBC_ST_IDLE
		&& tok.kind == USBC_TK_SETUP;

	// Sequencer state and answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= USBC_ST_IDLE;
			resp_q <= '0;
			ep_q <= 2'h0;
			setup_q <= 1'b0;
			take_q <= 1'b0;
			halt_q <= 1'b0;
		end else if (ce) begin
			resp_q.valid <= 1'b0;
			if (!usb_on) begin
				st_q <= USBC_ST_IDLE;
			end else begin
				case (st_q)
					USBC_ST_IDLE: begin
						if (hit && tok.kind == USBC_TK_IN) begin
							resp_q.valid <= 1'b1;
							resp_q.ep <= tok.ep;
							resp_q.pid1 <= epc[B_TOGGLE];
							resp_q.count <= epc[3:0];
							if (ep_halt) begin
								resp_q.hs <= USBC_HS_STALL;
							end else if (!epc[B_TX_RDY] || tx_done) begin
								resp_q.hs <= USBC_HS_NAK;
							end else begin
								resp_q.hs <= USBC_HS_DATA;
								st_q <= USBC_ST_ACK;
							end
							ep_q <= tok.ep;
						end else if (hit) begin
							st_q <= USBC_ST_RX;
							ep_q <= tok.ep;
							setup_q <= (tok.kind == USBC_TK_SETUP);
							halt_q <= ep_halt && tok.kind != USBC_TK_SETUP;
							take_q <= (tok.kind == USBC_TK_SETUP)
								|| (rx_ok && !ep_halt);
						end
					end
					USBC_ST_RX: begin
						if (rx_end) begin
							st_q <= USBC_ST_IDLE;
							resp_q.valid <= 1'b1;
							resp_q.ep <= ep_q;
							resp_q.count <= 4'h0;
							resp_q.pid1 <= 1'b0;
							if (halt_q) resp_q.hs <= USBC_HS_STALL;
							else if (take_q) resp_q.hs <= USBC_HS_ACK;
							else resp_q.hs <= USBC_HS_NAK;
						end
					end
					USBC_ST_ACK: begin
						if (host_ack || host_timeout || tok.valid) begin
							st_q <= USBC_ST_IDLE;
						end
					end
					default: st_q <= USBC_ST_IDLE;
				endcase
			end
		end
	end
	assign resp = resp_q;

	// Hardware flag events
	always_comb begin
		flag_set = 8'h00;
		flag_set[F_BUSRST] = se0_cnt_q == 8'(BUSRST_CYC - 1);
		flag_set[F_EOP] = se0_seen_q && jst;
		flag_set[F_RESUME] = ctl_q[4][B_SUSP] && !jst;
		if (st_q == USBC_ST_ACK && host_ack) begin
			flag_set[F_TX0] = (ep_q == 2'h0);
			flag_set[F_TX1] = (ep_q == 2'h1);
			flag_set[F_TX2] = (ep_q == 2'h2);
		end
		if (st_q == USBC_ST_RX && rx_end && take_q && !halt_q) begin
			flag_set[F_RX0] = (ep_q == 2'h0);
			flag_set[F_RX2] = (ep_q == 2'h2);
		end
	end

	// Bytes of a refused packet are dropped, not queued
	usbc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(rx_valid && st_q == USBC_ST_RX && take_q),
		.in_ready(fifo_ready),
		.in_data(rx_data),
		.out_valid(rxf_valid),
		.out_ready(rxf_ready),
		.out_data(rxf_data)
	);
	// Stall source only for bytes we keep
	assign rx_ready = fifo_ready || !(st_q == USBC_ST_RX && take_q);

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_in_tok;
		ce && hit && st_q == USBC_ST_IDLE && tok.kind == USBC_TK_IN;
	endsequence
	off_nodrive_a: assert property (!usb_on && !ctl_q[0][B_FORCE] |-> !dp_oe)
		else $error("pins driven while disabled");
	pull_on_a: assert property (ce && sfr_wr && sfr_addr == OFS_GLOBAL
		|=> pullup_on == ($past(sfr_wdata[B_PULL])
		&& $past(sfr_wdata[B_USB_ON])))
		else $error("pull-up mismatch");
	resume_k_a: assert property (usb_on && ctl_q[0][B_FRES]
		&& !ctl_q[0][B_FORCE] |-> dp_oe && !dp_o && dm_o)
		else $error("resume state not driven");
	force_lvl_a: assert property (ctl_q[0][B_FORCE] |-> dp_oe
		&& dp_o == ctl_q[0][B_FDP] && dm_o == ctl_q[0][B_FDM])
		else $error("forced levels wrong");
	in_nak_a: assert property (s_in_tok ##0 (!ep_halt && !epc[B_TX_RDY])
		|=> resp.valid && resp.hs == USBC_HS_NAK)
		else $error("IN not NAKed");
	in_stall_a: assert property (s_in_tok ##0 ep_halt
		|=> resp.valid && resp.hs == USBC_HS_STALL)
		else $error("IN not stalled");
	setup_clr_a: assert property (setup_hit |=> !ctl_q[1][B_HALT]
		&& !ctl_q[2][B_RX_RDY])
		else $error("halts kept after SETUP");
	setup_ack_a: assert property (st_q == USBC_ST_RX && setup_q && ce
		&& rx_end && usb_on |=> resp.hs == USBC_HS_ACK)
		else $error("SETUP not ACKed");
	toggle_a: assert property (s_in_tok |=> resp.pid1 == $past(epc[B_TOGGLE])
		&& resp.count == $past(epc[3:0]))
		else $error("toggle or count wrong");
	txdone_a: assert property (ce && st_q == USBC_ST_ACK && host_ack
		&& ep_q == 2'h1 |=> flag_q[F_TX1])
		else $error("transmit done not set");
	irq_mask_a: assert property (flag_q[6:0] != 0 && ctl_q[4][6:0] == 0
		&& !flag_q[F_RESUME] |-> !irq)
		else $error("masked flag raised interrupt");
endmodule

// file: shared/usbc_pkg.sv
// Package of constants and carriers for the USB endpoint control block
//----------------------------------------------------------------------
// Contract
// - Global enable clear stops all USB pin drive except forced direct output
// - Endpoint two answers only while enabled
// - Endpoint one answers IN only while enabled
// - Pull-up on needs pull enable and global enable
// - Force-resume drives resume state onto lines
// - Forced direct output drives programmed pin levels
// - Control IN NAKs unless ready and not done
// - Control OUT NAKs and discards unless ready
// - SETUP always accepted and ACKed
// - Control halts STALL; SETUP clears both halts
// - Toggle bit picks DATA1 or DATA0
// - Four-bit count sets IN bytes, zero to eight
// - Endpoint one IN NAKs unless ready, not done
// - Endpoint one halt STALLs every IN and OUT; SETUP still ACKed
// - Endpoint two IN NAKs unless ready, not done
// - Endpoint two OUT NAKs and discards unless ready
// - Endpoint two halt STALLs every IN and OUT; SETUP still ACKed
// - Each flag except resume interrupts only with its enable
// - Seven-bit address selects tokens for this device
// - Transmit done set after host ACK; write-one clears
// - Receive done set after store and ACK
// - Suspended bus activity sets resume flag, wakes
// - Bus reset and end-of-packet flags from lines
//----------------------------------------------------------------------
package usbc_pkg;
	// Register offsets on the special function bus
	localparam logic [7:0] OFS_GLOBAL = 8'hE4;
	localparam logic [7:0] OFS_STATUS = 8'hEA;
	localparam int NUM_CTL = 6;
	// Global control bit positions
	localparam int B_USB_ON = 7;
	localparam int B_EP2_ON = 6;
	localparam int B_EP1_ON = 5;
	localparam int B_PULL = 4;
	localparam int B_FRES = 3;
	localparam int B_FORCE = 2;
	localparam int B_FDP = 1;
	localparam int B_FDM = 0;
	// Endpoint control bits; count sits in [3:0]; suspend sits in the enable register
	localparam int B_TX_RDY = 7;
	localparam int B_RX_RDY = 6;
	localparam int B_HALT = 5;
	localparam int B_TOGGLE = 4;
	localparam int B_SUSP = 7;
	// Status flag bits, enables share positions 6..0
	localparam int F_RESUME = 7;
	localparam int F_BUSRST = 6;
	localparam int F_EOP = 5;
	localparam int F_TX2 = 4;
	localparam int F_RX2 = 3;
	localparam int F_TX1 = 2;
	localparam int F_TX0 = 1;
	localparam int F_RX0 = 0;
	localparam logic [7:0] RST_VAL = 8'h00;
	// Bus reset must hold SE0 this long before it counts
	localparam int CLK_NS = 20;
	localparam int T_BUSRST_NS = 2500;
	localparam int BUSRST_CYC = (T_BUSRST_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_DEPTH = 16;
	// Token kinds and handshake codes
	typedef enum logic [1:0] {
		USBC_TK_IN = 2'h0, USBC_TK_OUT = 2'h1, USBC_TK_SETUP = 2'h2
	} usbc_tok_kind_t;
	typedef enum logic [2:0] {
		USBC_HS_DATA = 3'h1, USBC_HS_ACK = 3'h2,
		USBC_HS_NAK = 3'h3, USBC_HS_STALL = 3'h4
	} usbc_hs_t;
	// Decoded token from the serial engine
	typedef struct packed {
		logic valid;
		usbc_tok_kind_t kind;
		logic [6:0] addr;
		logic [1:0] ep;
	} usbc_tok_t;
	// Answer handed to the serial engine
	typedef struct packed {
		logic valid;
		usbc_hs_t hs;
		logic pid1;
		logic [3:0] count;
		logic [1:0] ep;
	} usbc_resp_t;
endpackage

// file: test/test_usbc_ctrl.sv
// Self-checking bench for the USB endpoint control block
`timescale 1ns/1ps
module test_usbc_ctrl
	import usbc_pkg::*;
;
	//------------------------------------------------------------------
	// Signals and instances
	//------------------------------------------------------------------
	localparam logic [6:0] DEV = 7'h05; // Address given to the device
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata, rx_data, rxf_data;
	logic dp_i, dp_o, dp_oe, dm_i, dm_o, dm_oe, pullup_on;
	logic rx_valid, rx_end, rx_ready, host_ack, rxf_valid, wake, irq;
	logic rxf_ready = 1'b0;
	logic ce = 1'b1; // Clock enable, dropped once to prove the freeze
	logic sie_oe = 1'b0; // Engine drive request
	logic [1:0] last_ep = 2'h0; // Endpoint of the last token sent
	usbc_tok_t tok;
	usbc_resp_t resp;
	int error_cnt = 0;
	int check_count = 0;
	always #10 clk = ~clk;
	// Engine levels and timeout tied: only its drive request is modelled
	usbc_ctrl u_usbc_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .dp_i(dp_i),
		.dp_o(dp_o), .dp_oe(dp_oe), .dm_i(dm_i), .dm_o(dm_o),
		.dm_oe(dm_oe), .pullup_on(pullup_on), .sie_oe(sie_oe),
		.sie_dp(1'b1), .sie_dm(1'b0), .tok(tok), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_end(rx_end), .rx_ready(rx_ready),
		.host_ack(host_ack), .host_timeout(1'b0), .resp(resp),
		.rxf_valid(rxf_valid), .rxf_ready(rxf_ready),
		.rxf_data(rxf_data), .wake(wake), .irq(irq));
	usbc_host_model u_usbc_host_model (.clk(clk), .dp_o(dp_o),
		.dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe), .tok(tok),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.host_ack(host_ack), .dp_i(dp_i), .dm_i(dm_i));
	//------------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------------
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Register write: one-cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk) #1;
		sfr_wr = 1'b0;
	endtask
	// Register read: data lands the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) #1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk) #1;
		sfr_rd = 1'b0;
		@(posedge clk) #1;
		chk("register", {8'h00, exp}, {8'h00, sfr_rdata});
	endtask
	// Pin drive with levels masked by their enables
	function automatic logic [15:0] drv();
		return {12'h000, dp_oe, dm_oe, dp_o & dp_oe, dm_o & dm_oe};
	endfunction
	task automatic tk(input usbc_tok_kind_t k, input logic [1:0] e);
		last_ep = e;
		u_usbc_host_model.token(k, DEV, e);
	endtask
	// Wait for the answer; toggle and count matter only for data
	task automatic answer(input usbc_hs_t hs, input logic p,
		input logic [3:0] n);
		int i;
		logic d;
		d = (hs == USBC_HS_DATA);
		for (i = 0; i < 40 && resp.valid !== 1'b1; i++) begin
			@(posedge clk) #1;
		end
		if (i == 40) begin
			error_cnt++;
			$display("Error resp expected valid seen none");
			tally_and_finish();
		end else begin
			chk("resp", {6'h00, last_ep, hs, d ? {p, n} : 5'h00},
				{6'h00, resp.ep, resp.hs,
				d ? {resp.pid1, resp.count} : 5'h00});
		end
	endtask
	// No answer may appear; looks from the token's own edge on
	task automatic quiet();
		int hits = 0;
		repeat (12) begin
			if (resp.valid !== 1'b0) hits++;
			@(posedge clk) #1;
		end
		chk("silence", 16'h0000, 16'(hits));
	endtask
	//------------------------------------------------------------------
	// Sequence
	//------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		chk("idle pins", 16'h0000, {12'h000, drv() == 0, pullup_on, irq,
			rx_ready} ^ 16'h0009);
		for (logic [7:0] a = 8'hE4; a <= 8'hEA; a++) rd(a, 8'h00);
		rd(8'hE0, 8'h00); // Unmapped place reads zero
		wr(8'hE4, 8'h10);
		chk("pullup", 16'h0000, {15'h0000, pullup_on});
		wr(8'hE4, 8'h90);
		chk("pullup", 16'h0001, {15'h0000, pullup_on});
		chk("drive", 16'h0000, drv());
		wr(8'hE4, 8'h06);
		chk("drive", 16'h000E, drv());
		wr(8'hE4, 8'h05);
		chk("drive", 16'h000D, drv());
		sie_oe = 1'b1; // Engine asks to drive J from here
		wr(8'hE4, 8'h00);
		chk("drive", 16'h0000, drv());
		wr(8'hE4, 8'h88); // Resume beats the engine's request
		chk("drive", 16'h000D, drv());
		wr(8'hE4, 8'hF0); // Resume off: the engine's J request drives
		chk("drive", 16'h000E, drv());
		sie_oe = 1'b0;
		wr(8'hE9, {1'b0, DEV});
		ce = 1'b0; // Frozen: this write must not land
		wr(8'hE9, 8'h7F);
		ce = 1'b1;
		rd(8'hE9, {1'b0, DEV});
		// Control endpoint IN
		tk(USBC_TK_IN, 2'h0);
		answer(USBC_HS_NAK, 1'b0, 4'h0);
		u_usbc_host_model.token(USBC_TK_IN, 7'h06, 2'h0);
		quiet();
		wr(8'hE5, 8'h98);
		tk(USBC_TK_IN, 2'h0);
		answer(USBC_HS_DATA, 1'b1, 4'h8);
		u_usbc_host_model.ack();
		rd(8'hEA, 8'h02);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(8'hE8, 8'h02);
		chk("irq", 16'h0001, {15'h0000, irq});
		tk(USBC_TK_IN, 2'h0);
		answer(USBC_HS_NAK, 1'b0, 4'h0);
		wr(8'hEA, 8'h02);
		chk("irq", 16'h0000, {15'h0000, irq});
		// Endpoint one
		wr(8'hE6, 8'h83);
		tk(USBC_TK_IN, 2'h1);
		answer(USBC_HS_DATA, 1'b0, 4'h3);
		u_usbc_host_model.ack();
		rd(8'hEA, 8'h04);
		wr(8'hEA, 8'h04);
		wr(8'hE6, 8'h20);
		tk(USBC_TK_IN, 2'h1);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		tk(USBC_TK_OUT, 2'h1);
		u_usbc_host_model.bytes(8'h00, 0);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		wr(8'hE4, 8'hD0);
		tk(USBC_TK_IN, 2'h1);
		quiet();
		// Endpoint two IN and halt
		wr(8'hE4, 8'hB0);
		tk(USBC_TK_IN, 2'h2);
		quiet();
		wr(8'hE4, 8'hF0);
		wr(8'hE7, 8'h80);
		tk(USBC_TK_IN, 2'h2);
		answer(USBC_HS_DATA, 1'b0, 4'h0);
		u_usbc_host_model.ack();
		rd(8'hEA, 8'h10);
		wr(8'hEA, 8'h10);
		wr(8'hE7, 8'h20);
		tk(USBC_TK_IN, 2'h2);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		tk(USBC_TK_OUT, 2'h2);
		u_usbc_host_model.bytes(8'h00, 0);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		// Control endpoint OUT, halts and SETUP
		wr(8'hE5, 8'h00);
		tk(USBC_TK_OUT, 2'h0);
		u_usbc_host_model.bytes(8'hA0, 2);
		answer(USBC_HS_NAK, 1'b0, 4'h0);
		chk("fifo", 16'h0000, {15'h0000, rxf_valid});
		wr(8'hE5, 8'h20);
		wr(8'hE6, 8'h40);
		tk(USBC_TK_IN, 2'h0);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		tk(USBC_TK_OUT, 2'h0);
		u_usbc_host_model.bytes(8'h00, 0);
		answer(USBC_HS_STALL, 1'b0, 4'h0);
		tk(USBC_TK_SETUP, 2'h0);
		u_usbc_host_model.bytes(8'h10, 8);
		answer(USBC_HS_ACK, 1'b0, 4'h0);
		rd(8'hE5, 8'h00);
		rd(8'hE6, 8'h00);
		rd(8'hEA, 8'h01);
		// Endpoint two OUT fills the buffer
		wr(8'hE7, 8'h40);
		tk(USBC_TK_OUT, 2'h2);
		u_usbc_host_model.bytes(8'h18, 8);
		answer(USBC_HS_ACK, 1'b0, 4'h0);
		rd(8'hEA, 8'h09);
		tk(USBC_TK_OUT, 2'h2);
		u_usbc_host_model.bytes(8'h30, 1);
		answer(USBC_HS_NAK, 1'b0, 4'h0);
		rxf_ready = 1'b1;
		for (int i = 0; i < 16; i++) begin
			chk("fifo", {8'h01, 8'h10 + 8'(i)}, {7'h00, rxf_valid, rxf_data});
			@(posedge clk) #1;
		end
		rxf_ready = 1'b0;
		chk("fifo", 16'h0000, {15'h0000, rxf_valid});
		// Line events: bus reset, end of packet, resume
		wr(8'hEA, 8'hFF);
		u_usbc_host_model.line(1'b0, 1'b0, BUSRST_CYC + 15);
		u_usbc_host_model.line(1'b1, 1'b0, 8);
		rd(8'hEA, 8'h60);
		wr(8'hEA, 8'hFF);
		wr(8'hE8, 8'h80);
		u_usbc_host_model.line(1'b0, 1'b1, 10);
		u_usbc_host_model.line(1'b1, 1'b0, 6);
		chk("wake", 16'h0003, {14'h0000, wake, irq});
		wr(8'hE8, 8'h00);
		wr(8'hEA, 8'h80);
		chk("wake", 16'h0000, {14'h0000, wake, irq});
		tally_and_finish();
	end
endmodule

// file: test/usbc_host_model.sv
// Host-side model: tokens, packet bytes, handshakes and line levels
`timescale 1ns/1ps
module usbc_host_model
	import usbc_pkg::*;
(
	input wire logic clk,
	input wire logic dp_o,
	input wire logic dp_oe,
	input wire logic dm_o,
	input wire logic dm_oe,
	output usbc_tok_t tok,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic host_ack,
	output logic dp_i,
	output logic dm_i
);
	//------------------------------------------------------------------
	// Line and strobes
	//------------------------------------------------------------------
	logic hdp = 1'b1; // Host level on D+, idle J
	logic hdm = 1'b0; // Host level on D-
	// Device drive wins the wire, else the host level shows
	assign dp_i = dp_oe ? dp_o : hdp;
	assign dm_i = dm_oe ? dm_o : hdm;
	initial begin
		tok = '0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		host_ack = 1'b0;
	end
	// One-cycle token; address scrambled after so stale values never match
	task automatic token(input usbc_tok_kind_t k, input logic [6:0] a,
		input logic [1:0] e);
		@(posedge clk) #1;
		tok = {1'b1, k, a, e};
		@(posedge clk) #1;
		tok.valid = 1'b0;
		tok.addr = ~tok.addr;
	endtask
	// Data bytes two cycles apart, then end of packet
	task automatic bytes(input logic [7:0] first, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) #1;
			rx_valid = 1'b1;
			rx_data = first + 8'(i);
			@(posedge clk) #1;
			rx_valid = 1'b0;
			rx_data = ~rx_data;
		end
		@(posedge clk) #1;
		rx_end = 1'b1;
		@(posedge clk) #1;
		rx_end = 1'b0;
	endtask
	// Host handshake after our IN data
	task automatic ack();
		@(posedge clk) #1;
		host_ack = 1'b1;
		@(posedge clk) #1;
		host_ack = 1'b0;
	endtask
	// Hold a line state for n cycles
	task automatic line(input logic p, input logic m, input int n);
		hdp = p;
		hdm = m;
		repeat (n) @(posedge clk);
		#1;
	endtask
endmodule
